// ---- logic/ddl_consts.vh ----
// Constants for the dual converter byte-load host controller
`ifndef DDL_CONSTS_VH
`define DDL_CONSTS_VH
`define DDL_CODE_W        12
`define DDL_BYTE_W        8
`define DDL_HI_W          4
`define DDL_LO_LSB        0
`define DDL_HI_LSB        8
`define DDL_SETUP_NS      16
`define DDL_STROBE_NS     40
`define DDL_HOLD_NS       16
`define DDL_CLK_NS        8
// Phase counts in clock cycles, sized for the phase timer
`define DDL_SETUP_CYC     4'h2
`define DDL_STROBE_CYC    4'h5
`define DDL_HOLD_CYC      4'h2
`define DDL_CNT_W         4
`define DDL_FULL_SCALE    12'hFFF
`define DDL_MID_SCALE     12'h800
`define DDL_ZERO_SCALE    12'h000
`define DDL_MODE_STROBED  1'b0
`define DDL_MODE_AUTO     1'b1
`endif

// ---- logic/ddl_phase_timer.v ----
// Phase timer: counts the cycles of one bus-cycle phase
`timescale 1ns/100ps
`include "ddl_consts.vh"
module ddl_phase_timer (
    // Clock and reset
    input  wire                  clk,
    input  wire                  reset,
    // Control
    input  wire                  load,
    input  wire [`DDL_CNT_W-1:0] count,
    // Status
    output reg                   done_r
);
    reg [`DDL_CNT_W-1:0] cnt_r;

    always @(posedge clk or posedge reset) begin
        if (reset) begin
            cnt_r  <= 4'h0;
            done_r <= 1'b0;
        end else if (load) begin
            cnt_r  <= count;
            done_r <= 1'b0;
        end else if (cnt_r != 4'h0) begin
            cnt_r  <= cnt_r - 4'h1;
            done_r <= (cnt_r == 4'h1);
        end else begin
            done_r <= 1'b0;
        end
    end
endmodule // ddl_phase_timer

// ---- logic/ddl_host.v ----
// Host controller that loads and transfers codes into the dual converter
// Summary of operation
// R1: Half select low lower byte, high upper
// R2: Either half may go first
// R3: Upper half on low four data lines
// R4: Channel select low first, high second
// R5: Half follows data while load low
// R6: Transfer strobe copies both channels together
// R7: Both strobes low makes converter transparent
// R8: Converter registers capture on transfer rising
// R9: Reset low zeroes every register
// R10: Keep load high when releasing reset
// R11: Full scale calibration loads all ones
// R12: Bipolar zero is mid scale code
// R13: Auto mode: four writes, transfer held low (code pulses transfer low only with the second write of each channel)
// R14: Strobed mode: four writes plus transfer
// R15: Strobes idle high
`timescale 1ns/100ps
`include "ddl_consts.vh"
module ddl_host (
    // Clock and reset
    input  wire                  clk,
    input  wire                  reset,
    // User request
    input  wire                  req,
    input  wire                  mode,
    input  wire                  hi_first,
    input  wire [1:0]            cal_sel,
    input  wire [`DDL_CODE_W-1:0] code_a,
    input  wire [`DDL_CODE_W-1:0] code_b,
    input  wire                  zero_req,
    output reg                   busy_r,
    output reg                   done_r,
    // Converter pins
    output reg [`DDL_BYTE_W-1:0] data_r,
    output reg                   byte_hi_r,
    output reg                   chan_b_r,
    output reg                   load_strobe_n_r,
    output reg                   output_transfer_strobe_n_r,
    output reg                   conv_reset_n_r
);
    localparam ST_IDLE  = 6'b000001;
    localparam ST_SETUP = 6'b000010;
    localparam ST_PULSE = 6'b000100;
    localparam ST_HOLD  = 6'b001000;
    localparam ST_XFER  = 6'b010000;
    localparam ST_ZERO  = 6'b100000;

    reg [5:0]             state_r;
    reg [1:0]             step_r;
    reg                   mode_r;
    reg                   hi_first_r;
    reg [`DDL_CODE_W-1:0] word_a_r;
    reg [`DDL_CODE_W-1:0] word_b_r;
    reg [`DDL_CODE_W-1:0] word_a_nxt;
    reg [`DDL_CODE_W-1:0] word_b_nxt;
    reg                   tmr_load;
    reg [`DDL_CNT_W-1:0]  tmr_count;
    wire                  tmr_done;

    wire                  cur_hi   = step_r[0] ^ hi_first_r;            // [R2]
    wire                  cur_b    = step_r[1];                         // [R4]
    wire [`DDL_CODE_W-1:0] cur_word = cur_b ? word_b_r : word_a_r;
    wire                  last_of_ch = step_r[0];

    ddl_phase_timer u_tmr (
        .clk    (clk),
        .reset  (reset),
        .load   (tmr_load),
        .count  (tmr_count),
        .done_r (tmr_done)
    );

    // Calibration patterns override both channel codes
    always @* begin
        word_a_nxt = code_a;
        word_b_nxt = code_b;
        case (cal_sel)
            2'h1: begin
                word_a_nxt = `DDL_FULL_SCALE;                           // [R11]
                word_b_nxt = `DDL_FULL_SCALE;
            end
            2'h2: begin
                word_a_nxt = `DDL_MID_SCALE;                            // [R12]
                word_b_nxt = `DDL_MID_SCALE;
            end
            2'h3: begin
                word_a_nxt = `DDL_ZERO_SCALE;
                word_b_nxt = `DDL_ZERO_SCALE;
            end
            default: begin
                word_a_nxt = code_a;
                word_b_nxt = code_b;
            end
        endcase
    end

    always @* begin
        tmr_load  = 1'b0;
        tmr_count = 4'h0;
        case (state_r)
            ST_IDLE: begin
                tmr_load  = req | zero_req;
                tmr_count = zero_req ? `DDL_STROBE_CYC : `DDL_SETUP_CYC;
            end
            ST_SETUP: begin
                tmr_load  = tmr_done;
                tmr_count = `DDL_STROBE_CYC;
            end
            ST_PULSE: begin
                tmr_load  = tmr_done;
                tmr_count = `DDL_HOLD_CYC;
            end
            ST_HOLD: begin
                tmr_load  = tmr_done;
                tmr_count = (step_r == 2'h3 && mode_r == `DDL_MODE_STROBED)
                            ? `DDL_STROBE_CYC : `DDL_SETUP_CYC;
            end
            default: begin
                tmr_load  = 1'b0;
                tmr_count = 4'h0;
            end
        endcase
    end

    always @(posedge clk or posedge reset) begin
        if (reset) begin
            state_r                    <= ST_IDLE;
            step_r                     <= 2'h0;
            mode_r                     <= 1'b0;
            hi_first_r                 <= 1'b0;
            word_a_r                   <= 12'h000;
            word_b_r                   <= 12'h000;
            busy_r                     <= 1'b0;
            done_r                     <= 1'b0;
            data_r                     <= 8'h00;
            byte_hi_r                  <= 1'b0;
            chan_b_r                   <= 1'b0;
            load_strobe_n_r            <= 1'b1;                         // [R15]
            output_transfer_strobe_n_r <= 1'b1;
            conv_reset_n_r             <= 1'b0;                         // [R9]
        end else begin
            done_r <= 1'b0;
            case (state_r)
                ST_IDLE: begin
                    load_strobe_n_r            <= 1'b1;                 // [R10] [R15]
                    output_transfer_strobe_n_r <= 1'b1;
                    conv_reset_n_r             <= 1'b1;
                    if (zero_req) begin
                        conv_reset_n_r <= 1'b0;                         // [R9]
                        busy_r         <= 1'b1;
                        state_r        <= ST_ZERO;
                    end else if (req) begin
                        mode_r     <= mode;
                        hi_first_r <= hi_first;
                        word_a_r   <= word_a_nxt;                       // [R11] [R12]
                        word_b_r   <= word_b_nxt;
                        step_r  <= 2'h0;
                        busy_r  <= 1'b1;
                        state_r <= ST_SETUP;
                    end
                end
                ST_SETUP: begin
                    byte_hi_r <= cur_hi;                                // [R1]
                    chan_b_r  <= cur_b;                                 // [R4]
                    data_r    <= cur_hi                                 // [R3]
                        ? {4'h0, cur_word[`DDL_HI_LSB +: `DDL_HI_W]}
                        : cur_word[`DDL_LO_LSB +: `DDL_BYTE_W];
                    if (tmr_done) begin
                        load_strobe_n_r <= 1'b0;                        // [R5]
                        // Auto transfer: second byte of each channel under low transfer
                        if (mode_r == `DDL_MODE_AUTO && last_of_ch)
                            output_transfer_strobe_n_r <= 1'b0;         // [R13] [R7]
                        state_r <= ST_PULSE;
                    end
                end
                ST_PULSE: begin
                    if (tmr_done) begin
                        // Rising edge latches input half, and converter word too after a second byte in auto mode
                        load_strobe_n_r            <= 1'b1;             // [R5] [R8]
                        output_transfer_strobe_n_r <= 1'b1;
                        state_r                    <= ST_HOLD;
                    end
                end
                ST_HOLD: begin
                    if (tmr_done) begin
                        if (step_r != 2'h3) begin
                            step_r  <= step_r + 2'h1;
                            state_r <= ST_SETUP;
                        end else if (mode_r == `DDL_MODE_STROBED) begin
                            output_transfer_strobe_n_r <= 1'b0;         // [R14] [R6]
                            state_r                    <= ST_XFER;
                        end else begin
                            busy_r  <= 1'b0;
                            done_r  <= 1'b1;
                            state_r <= ST_IDLE;
                        end
                    end
                end
                ST_XFER: begin
                    if (tmr_done) begin
                        output_transfer_strobe_n_r <= 1'b1;             // [R8]
                        busy_r                     <= 1'b0;
                        done_r                     <= 1'b1;
                        state_r                    <= ST_IDLE;
                    end
                end
                ST_ZERO: begin
                    if (tmr_done) begin
                        conv_reset_n_r <= 1'b1;                         // [R10]
                        busy_r         <= 1'b0;
                        done_r         <= 1'b1;
                        state_r        <= ST_IDLE;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end
endmodule // ddl_host

// ---- tb/ddl_host_properties.sv ----
// Pin timing properties of the converter host controller
`timescale 1ns/100ps
module ddl_host_properties (
    // Clock and reset
    input wire logic       clk,
    input wire logic       reset,
    // Request side
    input wire logic       req,
    input wire logic       zero_req,
    input wire logic       busy_r,
    input wire logic       done_r,
    // Converter pins
    input wire logic [7:0] data_r,
    input wire logic       byte_hi_r,
    input wire logic       chan_b_r,
    input wire logic       load_strobe_n_r,
    input wire logic       output_transfer_strobe_n_r,
    input wire logic       conv_reset_n_r
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    sequence s_wr_low;
        !load_strobe_n_r[*6] ##1 load_strobe_n_r;
    endsequence
    sequence s_xfer_low;
        !output_transfer_strobe_n_r[*6] ##1 output_transfer_strobe_n_r;
    endsequence
    AST_XFER_WIDTH: assert property ($fell(output_transfer_strobe_n_r) |-> s_xfer_low)
        else $error("transfer strobe width");
    AST_WR_WIDTH: assert property ($fell(load_strobe_n_r) |-> s_wr_low)
        else $error("write strobe width");
    AST_WR_SETUP: assert property ($fell(load_strobe_n_r) |-> $stable(data_r)
        && $stable(byte_hi_r) && $stable(chan_b_r)) else $error("write setup");
    AST_WR_HOLD: assert property (!load_strobe_n_r |=> $stable(data_r)
        && $stable(byte_hi_r) && $stable(chan_b_r)) else $error("write hold");
    AST_HI_NIBBLE: assert property (!load_strobe_n_r && byte_hi_r |-> data_r[7:4] == 4'h0)
        else $error("upper half data");
    AST_IDLE: assert property (!busy_r |-> load_strobe_n_r && output_transfer_strobe_n_r)
        else $error("strobe low when idle");
    AST_TAKEN: assert property ((req || zero_req) && !busy_r |=> busy_r)
        else $error("request not taken");
    AST_DONE: assert property (done_r |-> !busy_r ##1 !done_r)
        else $error("done pulse");
    AST_XFER: assert property (!output_transfer_strobe_n_r |-> busy_r && conv_reset_n_r)
        else $error("stray transfer");
    AST_RST_REL: assert property ($rose(conv_reset_n_r) |-> load_strobe_n_r)
        else $error("reset released with load low");
    AST_ZERO: assert property ($fell(conv_reset_n_r) |-> ##[1:10] conv_reset_n_r)
        else $error("reset pulse too long");
endmodule // ddl_host_properties

// ---- tb/ddl_dev_model.sv ----
// Behavioural model of the dual converter latches
`timescale 1ns/100ps
module ddl_dev_model (
    // Bus pins
    input wire logic [7:0] data,
    input wire logic       byte_hi,
    input wire logic       chan_b,
    input wire logic       load_strobe_n,
    input wire logic       output_transfer_strobe_n,
    input wire logic       reset_n,
    // Converter words
    output logic    [11:0] word_a,
    output logic    [11:0] word_b
);
    logic [11:0] in_a;
    logic [11:0] in_b;
    // Level latches, so strobe glitches corrupt data as on the real part
    always @* begin
        if (!reset_n) begin
            in_a = 12'h000;
            in_b = 12'h000;
        end else if (!load_strobe_n) begin
            if (!chan_b && !byte_hi) in_a[7:0] = data;
            if (!chan_b && byte_hi) in_a[11:8] = data[3:0];
            if (chan_b && !byte_hi) in_b[7:0] = data;
            if (chan_b && byte_hi) in_b[11:8] = data[3:0];
        end
    end
    always @* begin
        if (!reset_n) begin
            word_a = 12'h000;
            word_b = 12'h000;
        end else if (!output_transfer_strobe_n) begin
            word_a = in_a;
            word_b = in_b;
        end
    end
endmodule // ddl_dev_model

// ---- tb/ddl_host_tb.sv ----
// Self-checking bench for the converter host controller
`timescale 1ns/100ps
`include "ddl_consts.vh"
module ddl_host_tb;
    reg         clk = 1'b0;
    reg         reset = 1'b1;
    reg         req = 1'b0;
    reg         mode = 1'b0;
    reg         hi_first = 1'b0;
    reg   [1:0] cal_sel = 2'h0;
    reg  [11:0] code_a = 12'h000;
    reg  [11:0] code_b = 12'h000;
    reg         zero_req = 1'b0;
    wire        busy_r, done_r, byte_hi_r, chan_b_r, conv_reset_n_r;
    wire        load_strobe_n_r, output_transfer_strobe_n_r;
    wire  [7:0] data_r;
    wire [11:0] word_a, word_b;
    integer     errors = 0;
    integer     n_compared = 0;
    integer     nl, nx, i;
    reg         pl, px;
    always #4 clk = ~clk;
    ddl_host ddl_host_i (.clk, .reset, .req, .mode, .hi_first, .cal_sel, .code_a, .code_b,
        .zero_req, .busy_r, .done_r, .data_r, .byte_hi_r, .chan_b_r, .load_strobe_n_r,
        .output_transfer_strobe_n_r, .conv_reset_n_r);
    ddl_dev_model ddl_dev_model_i (.data(data_r), .byte_hi(byte_hi_r), .chan_b(chan_b_r),
        .load_strobe_n(load_strobe_n_r), .output_transfer_strobe_n(output_transfer_strobe_n_r),
        .reset_n(conv_reset_n_r), .word_a, .word_b);
    task check(input string nm, input [11:0] seen, input [11:0] exp);
        n_compared = n_compared + 1;
        if (seen !== exp) begin
            errors = errors + 1;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task print_verdict;
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // Counts strobe falls on the way, bounded so a hang ends the run
    task wait_done;
        nl = 0;
        nx = 0;
        pl = 1'b1;
        px = 1'b1;
        for (i = 0; i < 200 && done_r !== 1'b1; i = i + 1) begin
            @(posedge clk);
            if (load_strobe_n_r === 1'b0 && pl === 1'b1) nl = nl + 1;
            if (output_transfer_strobe_n_r === 1'b0 && px === 1'b1) nx = nx + 1;
            pl = load_strobe_n_r;
            px = output_transfer_strobe_n_r;
        end
        if (i == 200) begin
            errors = errors + 1;
            print_verdict;
        end
    endtask
    task run(input m, input hf, input [1:0] cs, input [11:0] a, input [11:0] b,
             input [11:0] ea, input [11:0] eb);
        mode <= m;
        hi_first <= hf;
        cal_sel <= cs;
        code_a <= a;
        code_b <= b;
        req <= 1'b1;
        @(posedge clk);
        req <= 1'b0;
        wait_done;
        check("loads", nl[11:0], 12'h004);
        check("transfers", nx[11:0], m ? 12'h002 : 12'h001);
        check("word_a", word_a, ea);
        check("word_b", word_b, eb);
    endtask
    task t_reset;
        check("word_a", word_a, `DDL_ZERO_SCALE);
        check("word_b", word_b, `DDL_ZERO_SCALE);
        $display("test reset done");
    endtask
    task t_modes;
        run(`DDL_MODE_STROBED, 1'b0, 2'h0, 12'hABC, 12'h5F3, 12'hABC, 12'h5F3);
        run(`DDL_MODE_STROBED, 1'b1, 2'h0, 12'h0F0, 12'hF0F, 12'h0F0, 12'hF0F);
        run(`DDL_MODE_AUTO, 1'b1, 2'h0, 12'h123, 12'hEDC, 12'h123, 12'hEDC);
        run(`DDL_MODE_AUTO, 1'b0, 2'h0, 12'hFFE, 12'h001, 12'hFFE, 12'h001);
        $display("test modes done");
    endtask
    task t_cal;
        run(`DDL_MODE_STROBED, 1'b0, 2'h1, 12'h000, 12'h000,
            `DDL_FULL_SCALE, `DDL_FULL_SCALE);
        run(`DDL_MODE_AUTO, 1'b1, 2'h2, 12'h000, 12'h000, `DDL_MID_SCALE, `DDL_MID_SCALE);
        run(`DDL_MODE_STROBED, 1'b1, 2'h3, 12'h777, 12'h777,
            `DDL_ZERO_SCALE, `DDL_ZERO_SCALE);
        $display("test calibration done");
    endtask
    task t_zero;
        run(`DDL_MODE_AUTO, 1'b0, 2'h0, 12'h777, 12'h999, 12'h777, 12'h999);
        zero_req <= 1'b1;
        @(posedge clk);
        zero_req <= 1'b0;
        wait_done;
        check("word_a", word_a, `DDL_ZERO_SCALE);
        check("word_b", word_b, `DDL_ZERO_SCALE);
        $display("test zero done");
    endtask
    initial begin
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        t_reset;
        t_modes;
        t_cal;
        t_zero;
        print_verdict;
    end
endmodule // ddl_host_tb
bind ddl_host ddl_host_properties ddl_host_properties_i (.clk, .reset, .req, .zero_req,
    .busy_r, .done_r, .data_r, .byte_hi_r, .chan_b_r, .load_strobe_n_r,
    .output_transfer_strobe_n_r, .conv_reset_n_r);
